// ### rtl/fsb_cpu_end.sv
// processor end of the host bus: symmetric arbitration, four-beat data,
// breakpoint monitor lines and bus frequency select; holds the send queue
// assumes the hub end keeps its own side of the arbitration handshake
//
// Summary of operation
// - drive four breakpoint lines, two are two-way
// - priority request seen: no new requests unless locked
// - priority agent holds request until its transfers finish
// - symmetric request line asks for the bus
// - three-bit select names the bus clock frequency
// - all agents run on one common clock
// - 64-bit data, driver asserts data ready
// - one transfer per bus clock period, four per line
// - capture data on falling edge of either strobe
// - four 16-bit groups, each with strobe pair
`timescale 1ns/10ps
`default_nettype none
module line_fifo
  import fsb_pkg::*;
#(
  parameter int WIDTH = LINE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             reset_n,   // sync reset, active low
  input  wire logic             inValid,   // word offered
  input  wire logic [WIDTH-1:0] inData,    // word offered
  output logic                  inReady,   // room for a word
  output logic                  outValid,  // word waiting
  output logic      [WIDTH-1:0] outData,   // oldest word
  input  wire logic             outReady   // drain takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             inReady_r, inReady_nxt;
  logic             push;
  logic             pop;

  assign inReady  = inReady_r;
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  always_comb begin
    push        = inValid && inReady_r;
    pop         = outValid && outReady;
    wrPtr_nxt   = push ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt   = pop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt   = (AW+1)'(count_r + push - pop);
    inReady_nxt = (count_nxt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      count_r   <= '0;
      inReady_r <= 1'b0;
    end else begin
      wrPtr_r   <= wrPtr_nxt;
      rdPtr_r   <= rdPtr_nxt;
      count_r   <= count_nxt;
      inReady_r <= inReady_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule

module fsb_cpu_end
  import fsb_pkg::*;
(
  input  wire logic              clk_sys,    // system clock
  input  wire logic              reset_n,    // sync reset, active low
  fsb_link_if.cpu                link,       // bus toward the hub
  input  wire logic              wrValid,    // line offered for sending
  input  wire logic [LINE_W-1:0] wrData,     // line to send
  output logic                   wrReady,    // send queue has room
  output logic                   rdValid,    // line received, pulse
  output logic      [LINE_W-1:0] rdData,     // received line
  input  wire logic              lockedOp,   // locked sequence running
  input  wire logic [FREQ_W-1:0] freqStrap,  // caught once after reset
  input  wire logic [BPM_W-1:0]  bpmEvent,   // breakpoint/counter status
  input  wire logic              bpmProbe,   // tool owns two-way lines
  output logic      [BPM_W-1:0]  bpmSeen     // monitor lines as seen
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_XFER = 3'b100
  } cpu_state_t;

  logic              fifoValid, fifoReady, txFree;
  logic [LINE_W-1:0] fifoData;
  logic              txReq_r, txReq_nxt;
  logic [LINE_W-1:0] txHold_r, txHold_nxt;
  logic              ackMeta_r, ackSync_r, rxMeta_r, rxSync_r, rxSeen_r;
  logic              rdValid_r, rdValid_nxt;
  logic [LINE_W-1:0] rdData_r, rdData_nxt;
  logic [FREQ_W-1:0] freqSel_r, freqSel_nxt;
  logic              strapDone_r;
  logic [BPM_W-1:0]  bpmMeta_r, bpmSeen_r;
  logic              linkRstMeta_r, linkRstN_r;
  logic              reqMeta_r, reqSync_r, lockMeta_r, lockSync_r;
  logic              probeMeta_r, probeSync_r;
  logic [BPM_W-1:0]  evtMeta_r, evtSync_r;
  logic [FREQ_W-1:0] freqMeta_r, freqSync_r;
  cpu_state_t        state_r, state_nxt;
  beat_t             beat_r, beat_nxt;
  logic              txAck_r, txAck_nxt, txPend, priFree, driving;
  logic              symReqN_r, symReqN_nxt, dataOeN_r, dataOeN_nxt;
  logic [BUS_W-1:0]  data_r, data_nxt;
  logic [NGRP-1:0]   stbP_r, stbP_nxt, stbN_r, stbN_nxt;
  logic [NGRP-1:0]   prevP_r, prevN_r, fell;
  logic [BPM_W-1:0]  bpm_r, bpm_nxt, bpmOeN_r, bpmOeN_nxt;
  logic [FREQ_W-1:0] freqOut_r;
  beat_t             rxCnt_r [NGRP];
  beat_t             rxCnt_nxt [NGRP];
  logic [LINE_W-1:0] rxLine_r, rxLine_nxt;
  logic              rxTog_r, rxTog_nxt;

  line_fifo #(.WIDTH(LINE_W), .DEPTH(FIFO_DEPTH)) sendQueue (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  (wrValid),
    .inData   (wrData),
    .inReady  (wrReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoReady)
  );

  assign rdValid = rdValid_r;
  assign rdData  = rdData_r;
  assign bpmSeen = bpmSeen_r;

  // one line in flight; the queue stalls until the link acknowledges
  always_comb begin
    txFree      = (txReq_r == ackSync_r);
    fifoReady   = txFree;
    txReq_nxt   = txReq_r;
    txHold_nxt  = txHold_r;
    if (txFree && fifoValid) begin
      txReq_nxt  = ~txReq_r;
      txHold_nxt = fifoData;
    end
    rdValid_nxt = (rxSync_r != rxSeen_r);
    rdData_nxt  = rdValid_nxt ? rxLine_r : rdData_r;
    freqSel_nxt = strapDone_r ? freqSel_r : freqStrap;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txReq_r     <= 1'b0;
      txHold_r    <= '0;
      ackMeta_r   <= 1'b0;
      ackSync_r   <= 1'b0;
      rxMeta_r    <= 1'b0;
      rxSync_r    <= 1'b0;
      rxSeen_r    <= 1'b0;
      rdValid_r   <= 1'b0;
      rdData_r    <= '0;
      freqSel_r   <= FREQ_RST;
      strapDone_r <= 1'b0;
      bpmMeta_r   <= '0;
      bpmSeen_r   <= '0;
    end else begin
      txReq_r     <= txReq_nxt;
      txHold_r    <= txHold_nxt;
      ackMeta_r   <= txAck_r;
      ackSync_r   <= ackMeta_r;
      rxMeta_r    <= rxTog_r;
      rxSync_r    <= rxMeta_r;
      rxSeen_r    <= rxSync_r;
      rdValid_r   <= rdValid_nxt;
      rdData_r    <= rdData_nxt;
      freqSel_r   <= freqSel_nxt;
      strapDone_r <= 1'b1;
      bpmMeta_r   <= ~link.breakpointMonitorLinesN;
      bpmSeen_r   <= bpmMeta_r;
    end
  end

  // link reset follows the system reset through two link flops
  always_ff @(posedge link.linkClk) begin
    linkRstMeta_r <= reset_n;
    linkRstN_r    <= linkRstMeta_r;
  end

  assign fell = (prevP_r & ~link.dataStrobePositiveN)
              | (prevN_r & ~link.dataStrobeNegativeN);

  always_comb begin
    txPend    = (reqSync_r != txAck_r);
    priFree   = link.priorityBusRequestN;
    state_nxt = state_r;
    beat_nxt  = beat_r;
    txAck_nxt = txAck_r;
    unique case (state_r)
      ST_IDLE: begin
        if (txPend && priFree) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        if (txPend && (priFree || lockSync_r)) begin
          state_nxt = ST_XFER;
          beat_nxt  = '0;
        end else if (!lockSync_r && (!priFree || !txPend)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_XFER: begin
        beat_nxt = beat_t'(beat_r + 2'h1);
        if (beat_r == LAST_BEAT) begin
          txAck_nxt = ~txAck_r;
          state_nxt = ST_REQ;  // a locked sequence keeps the bus
        end
      end
    endcase
    driving     = (state_nxt == ST_XFER);
    symReqN_nxt = (state_nxt == ST_IDLE);
    dataOeN_nxt = ~driving;
    data_nxt    = driving ? txHold_r[int'(beat_nxt) * BUS_W +: BUS_W]
                          : '1;
    stbP_nxt    = {NGRP{driving ? stbPosLevel(beat_nxt) : 1'b1}};
    stbN_nxt    = {NGRP{driving ? stbNegLevel(beat_nxt) : 1'b1}};
    bpm_nxt     = ~evtSync_r;
    bpmOeN_nxt  = probeSync_r ? BPM_TWO_WAY : '0;
    rxLine_nxt  = rxLine_r;
    rxTog_nxt   = rxTog_r;
    rxCnt_nxt   = rxCnt_r;
    for (int g = 0; g < NGRP; g++) begin
      if (link.dataReadyLineN) begin
        rxCnt_nxt[g] = '0;
      end else if (fell[g] && dataOeN_r) begin
        rxLine_nxt   = placeGroup(rxLine_nxt, rxCnt_r[g], g,
                         link.dataLines[g * GRP_W +: GRP_W]);
        rxCnt_nxt[g] = beat_t'(rxCnt_r[g] + 2'h1);
        if (g == 0 && rxCnt_r[g] == LAST_BEAT) begin
          rxTog_nxt = ~rxTog_r;
        end
      end
    end
  end

  always_ff @(posedge link.linkClk) begin
    if (!linkRstN_r) begin
      reqMeta_r   <= 1'b0;
      reqSync_r   <= 1'b0;
      lockMeta_r  <= 1'b0;
      lockSync_r  <= 1'b0;
      probeMeta_r <= 1'b0;
      probeSync_r <= 1'b0;
      evtMeta_r   <= '0;
      evtSync_r   <= '0;
      freqMeta_r  <= FREQ_RST;
      freqSync_r  <= FREQ_RST;
      freqOut_r   <= FREQ_RST;
      state_r     <= ST_IDLE;
      beat_r      <= '0;
      txAck_r     <= 1'b0;
      symReqN_r   <= 1'b1;
      dataOeN_r   <= 1'b1;
      data_r      <= '1;
      stbP_r      <= '1;
      stbN_r      <= '1;
      prevP_r     <= '1;
      prevN_r     <= '1;
      bpm_r       <= '1;
      bpmOeN_r    <= '0;
      rxCnt_r     <= '{default: '0};
      rxLine_r    <= '0;
      rxTog_r     <= 1'b0;
    end else begin
      reqMeta_r   <= txReq_r;
      reqSync_r   <= reqMeta_r;
      lockMeta_r  <= lockedOp;
      lockSync_r  <= lockMeta_r;
      probeMeta_r <= bpmProbe;
      probeSync_r <= probeMeta_r;
      evtMeta_r   <= bpmEvent;
      evtSync_r   <= evtMeta_r;
      freqMeta_r  <= freqSel_r;
      freqSync_r  <= freqMeta_r;
      freqOut_r   <= freqSync_r;
      state_r     <= state_nxt;
      beat_r      <= beat_nxt;
      txAck_r     <= txAck_nxt;
      symReqN_r   <= symReqN_nxt;
      dataOeN_r   <= dataOeN_nxt;
      data_r      <= data_nxt;
      stbP_r      <= stbP_nxt;
      stbN_r      <= stbN_nxt;
      prevP_r     <= link.dataStrobePositiveN;
      prevN_r     <= link.dataStrobeNegativeN;
      bpm_r       <= bpm_nxt;
      bpmOeN_r    <= bpmOeN_nxt;
      rxCnt_r     <= rxCnt_nxt;
      rxLine_r    <= rxLine_nxt;
      rxTog_r     <= rxTog_nxt;
    end
  end

  assign link.symmetricBusRequestN = symReqN_r;
  assign link.busFrequencySelect   = freqOut_r;
  assign link.cpuBpmN              = bpm_r;
  assign link.cpuBpmOeN            = bpmOeN_r;
  assign link.cpuData              = data_r;
  assign link.cpuDataOeN           = dataOeN_r;
  assign link.cpuReadyN            = dataOeN_r;
  assign link.cpuStbPN             = stbP_r;
  assign link.cpuStbNN             = stbN_r;
endmodule
`default_nettype wire

// ### rtl/fsb_hub_end.sv
// hub end of the host bus: priority arbitration and four-beat data,
// observes monitor lines and the frequency select of the processor end
// assumes the processor end withdraws its request when priority is seen
`timescale 1ns/10ps
`default_nettype none
module fsb_hub_end
  import fsb_pkg::*;
(
  input  wire logic              clk_sys,      // system clock
  input  wire logic              reset_n,      // sync reset, active low
  fsb_link_if.hub                link,         // bus toward the processor
  input  wire logic              sendValid,    // line offered for sending
  input  wire logic [LINE_W-1:0] sendData,     // line to send
  output logic                   sendReady,    // line can be taken
  output logic                   recvValid,    // line received, pulse
  output logic      [LINE_W-1:0] recvData,     // received line
  input  wire logic [FREQ_W-1:0] expectFreq,   // frequency the hub runs at
  output logic                   freqMismatch, // select differs from hub
  output logic      [BPM_W-1:0]  bpmSeen       // monitor lines as seen
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_ASK  = 3'b010,
    HS_XFER = 3'b100
  } hub_state_t;

  logic              txReq_r, txReq_nxt, sendReady_r, sendReady_nxt;
  logic [LINE_W-1:0] txHold_r, txHold_nxt;
  logic              ackMeta_r, ackSync_r, rxMeta_r, rxSync_r, rxSeen_r;
  logic              recvValid_r, recvValid_nxt;
  logic [LINE_W-1:0] recvData_r, recvData_nxt;
  logic [FREQ_W-1:0] freqMeta_r, freqSync_r;
  logic              mismatch_r;
  logic [BPM_W-1:0]  bpmMeta_r, bpmSeen_r;
  logic              linkRstMeta_r, linkRstN_r;
  logic              reqMeta_r, reqSync_r;
  hub_state_t        state_r, state_nxt;
  beat_t             beat_r, beat_nxt;
  logic              txAck_r, txAck_nxt, txPend, driving;
  logic              priReqN_r, priReqN_nxt, dataOeN_r, dataOeN_nxt;
  logic [BUS_W-1:0]  data_r, data_nxt;
  logic [NGRP-1:0]   stbP_r, stbP_nxt, stbN_r, stbN_nxt;
  logic [NGRP-1:0]   prevP_r, prevN_r, fell;
  beat_t             rxCnt_r [NGRP];
  beat_t             rxCnt_nxt [NGRP];
  logic [LINE_W-1:0] rxLine_r, rxLine_nxt;
  logic              rxTog_r, rxTog_nxt;

  assign sendReady    = sendReady_r;
  assign recvValid    = recvValid_r;
  assign recvData     = recvData_r;
  assign freqMismatch = mismatch_r;
  assign bpmSeen      = bpmSeen_r;

  always_comb begin
    txReq_nxt  = txReq_r;
    txHold_nxt = txHold_r;
    if (sendValid && sendReady_r) begin
      txReq_nxt  = ~txReq_r;
      txHold_nxt = sendData;
    end
    sendReady_nxt = (txReq_nxt == ackSync_r);
    recvValid_nxt = (rxSync_r != rxSeen_r);
    recvData_nxt  = recvValid_nxt ? rxLine_r : recvData_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txReq_r     <= 1'b0;
      txHold_r    <= '0;
      sendReady_r <= 1'b0;
      ackMeta_r   <= 1'b0;
      ackSync_r   <= 1'b0;
      rxMeta_r    <= 1'b0;
      rxSync_r    <= 1'b0;
      rxSeen_r    <= 1'b0;
      recvValid_r <= 1'b0;
      recvData_r  <= '0;
      freqMeta_r  <= FREQ_RST;
      freqSync_r  <= FREQ_RST;
      mismatch_r  <= 1'b0;
      bpmMeta_r   <= '0;
      bpmSeen_r   <= '0;
    end else begin
      txReq_r     <= txReq_nxt;
      txHold_r    <= txHold_nxt;
      sendReady_r <= sendReady_nxt;
      ackMeta_r   <= txAck_r;
      ackSync_r   <= ackMeta_r;
      rxMeta_r    <= rxTog_r;
      rxSync_r    <= rxMeta_r;
      rxSeen_r    <= rxSync_r;
      recvValid_r <= recvValid_nxt;
      recvData_r  <= recvData_nxt;
      freqMeta_r  <= link.busFrequencySelect;
      freqSync_r  <= freqMeta_r;
      mismatch_r  <= (freqSync_r != expectFreq);
      bpmMeta_r   <= ~link.breakpointMonitorLinesN;
      bpmSeen_r   <= bpmMeta_r;
    end
  end

  always_ff @(posedge link.linkClk) begin
    linkRstMeta_r <= reset_n;
    linkRstN_r    <= linkRstMeta_r;
  end

  assign fell = (prevP_r & ~link.dataStrobePositiveN)
              | (prevN_r & ~link.dataStrobeNegativeN);

  // the processor end is known idle once its request line reads high
  always_comb begin
    txPend    = (reqSync_r != txAck_r);
    state_nxt = state_r;
    beat_nxt  = beat_r;
    txAck_nxt = txAck_r;
    unique case (state_r)
      HS_IDLE: begin
        if (txPend) begin
          state_nxt = HS_ASK;
        end
      end
      HS_ASK: begin
        if (link.symmetricBusRequestN) begin
          state_nxt = HS_XFER;
          beat_nxt  = '0;
        end
      end
      HS_XFER: begin
        beat_nxt = beat_t'(beat_r + 2'h1);
        if (beat_r == LAST_BEAT) begin
          txAck_nxt = ~txAck_r;
          state_nxt = HS_IDLE;
        end
      end
    endcase
    driving     = (state_nxt == HS_XFER);
    priReqN_nxt = (state_nxt == HS_IDLE);
    dataOeN_nxt = ~driving;
    data_nxt    = driving ? txHold_r[int'(beat_nxt) * BUS_W +: BUS_W]
                          : '1;
    stbP_nxt    = {NGRP{driving ? stbPosLevel(beat_nxt) : 1'b1}};
    stbN_nxt    = {NGRP{driving ? stbNegLevel(beat_nxt) : 1'b1}};
    rxLine_nxt  = rxLine_r;
    rxTog_nxt   = rxTog_r;
    rxCnt_nxt   = rxCnt_r;
    for (int g = 0; g < NGRP; g++) begin
      if (link.dataReadyLineN) begin
        rxCnt_nxt[g] = '0;
      end else if (fell[g] && dataOeN_r) begin
        rxLine_nxt   = placeGroup(rxLine_nxt, rxCnt_r[g], g,
                         link.dataLines[g * GRP_W +: GRP_W]);
        rxCnt_nxt[g] = beat_t'(rxCnt_r[g] + 2'h1);
        if (g == 0 && rxCnt_r[g] == LAST_BEAT) begin
          rxTog_nxt = ~rxTog_r;
        end
      end
    end
  end

  always_ff @(posedge link.linkClk) begin
    if (!linkRstN_r) begin
      reqMeta_r <= 1'b0;
      reqSync_r <= 1'b0;
      state_r   <= HS_IDLE;
      beat_r    <= '0;
      txAck_r   <= 1'b0;
      priReqN_r <= 1'b1;
      dataOeN_r <= 1'b1;
      data_r    <= '1;
      stbP_r    <= '1;
      stbN_r    <= '1;
      prevP_r   <= '1;
      prevN_r   <= '1;
      rxCnt_r   <= '{default: '0};
      rxLine_r  <= '0;
      rxTog_r   <= 1'b0;
    end else begin
      reqMeta_r <= txReq_r;
      reqSync_r <= reqMeta_r;
      state_r   <= state_nxt;
      beat_r    <= beat_nxt;
      txAck_r   <= txAck_nxt;
      priReqN_r <= priReqN_nxt;
      dataOeN_r <= dataOeN_nxt;
      data_r    <= data_nxt;
      stbP_r    <= stbP_nxt;
      stbN_r    <= stbN_nxt;
      prevP_r   <= link.dataStrobePositiveN;
      prevN_r   <= link.dataStrobeNegativeN;
      rxCnt_r   <= rxCnt_nxt;
      rxLine_r  <= rxLine_nxt;
      rxTog_r   <= rxTog_nxt;
    end
  end

  assign link.priorityBusRequestN = priReqN_r;
  assign link.hubData             = data_r;
  assign link.hubDataOeN          = dataOeN_r;
  assign link.hubReadyN           = dataOeN_r;
  assign link.hubStbPN            = stbP_r;
  assign link.hubStbNN            = stbN_r;
endmodule
`default_nettype wire

// ### rtl/fsb_link_if.sv
// link between the processor end and the hub end of the host bus
// assumes the bench drives linkClk; idle active-low lines read high
`timescale 1ns/10ps
`default_nettype none
interface fsb_link_if (
  input wire logic linkClk  // common bus clock
);
  import fsb_pkg::*;

  logic                  symmetricBusRequestN;
  logic                  priorityBusRequestN;
  logic [FREQ_W-1:0]     busFrequencySelect;
  logic [BPM_W-1:0]      cpuBpmN;
  logic [BPM_W-1:0]      cpuBpmOeN;
  logic [BPM_W-1:0]      breakpointMonitorLinesN;
  logic [BUS_W-1:0]      cpuData;
  logic [BUS_W-1:0]      hubData;
  logic [BUS_W-1:0]      dataLines;
  logic                  cpuDataOeN;
  logic                  hubDataOeN;
  logic                  cpuReadyN;
  logic                  hubReadyN;
  logic                  dataReadyLineN;
  logic [NGRP-1:0]       cpuStbPN;
  logic [NGRP-1:0]       cpuStbNN;
  logic [NGRP-1:0]       hubStbPN;
  logic [NGRP-1:0]       hubStbNN;
  logic [NGRP-1:0]       dataStrobePositiveN;
  logic [NGRP-1:0]       dataStrobeNegativeN;

  // released pins are pulled high
  assign breakpointMonitorLinesN = cpuBpmN | cpuBpmOeN;
  assign dataLines = !cpuDataOeN ? cpuData :
                     (!hubDataOeN ? hubData : '1);
  assign dataReadyLineN = !cpuDataOeN ? cpuReadyN :
                          (!hubDataOeN ? hubReadyN : 1'b1);
  assign dataStrobePositiveN = !cpuDataOeN ? cpuStbPN :
                               (!hubDataOeN ? hubStbPN : '1);
  assign dataStrobeNegativeN = !cpuDataOeN ? cpuStbNN :
                               (!hubDataOeN ? hubStbNN : '1);

  modport cpu (
    input  linkClk, priorityBusRequestN, dataLines, dataReadyLineN,
           dataStrobePositiveN, dataStrobeNegativeN,
           breakpointMonitorLinesN,
    output symmetricBusRequestN, busFrequencySelect, cpuBpmN, cpuBpmOeN,
           cpuData, cpuDataOeN, cpuReadyN, cpuStbPN, cpuStbNN
  );

  modport hub (
    input  linkClk, symmetricBusRequestN, busFrequencySelect, dataLines,
           dataReadyLineN, dataStrobePositiveN, dataStrobeNegativeN,
           breakpointMonitorLinesN,
    output priorityBusRequestN, hubData, hubDataOeN, hubReadyN,
           hubStbPN, hubStbNN
  );
endinterface
`default_nettype wire

// ### rtl/fsb_pkg.sv
// constants and helpers shared by both ends of the host bus data link
// assumes both ends see one common link clock and one line = four beats
package fsb_pkg;
  localparam int BUS_W      = 64;
  localparam int GRP_W      = 16;
  localparam int NGRP       = 4;
  localparam int BEATS      = 4;
  localparam int LINE_W     = BUS_W * BEATS;
  localparam int FIFO_DEPTH = 16;
  localparam int FREQ_W     = 3;
  localparam int BPM_W      = 4;

  localparam logic [BPM_W-1:0]  BPM_TWO_WAY = 4'h9;
  localparam logic [1:0]        LAST_BEAT   = 2'h3;
  localparam logic [FREQ_W-1:0] FREQ_RST    = 3'h0;

  typedef logic [1:0] beat_t;

  // positive strobe falls on even beats, negative strobe on odd beats
  function automatic logic stbPosLevel(beat_t b);
    return b[0];
  endfunction

  function automatic logic stbNegLevel(beat_t b);
    return ~b[0];
  endfunction

  // drop one 16-bit group of one beat into its slot of a line
  function automatic logic [LINE_W-1:0] placeGroup(
    logic [LINE_W-1:0] line,
    beat_t             b,
    int                g,
    logic [GRP_W-1:0]  v
  );
    logic [LINE_W-1:0] r;
    r = line;
    r[int'(b) * BUS_W + g * GRP_W +: GRP_W] = v;
    return r;
  endfunction
endpackage

// ### tb/fsb_link_sva.sv
// link checker: arbitration, burst and strobe relations on the link wires
// assumes reset_n is the bench reset and linkClk samples every link signal
`timescale 1ns/10ps
`default_nettype none
module fsb_link_sva
  import fsb_pkg::*;
(
  input wire logic             linkClk,              // bus clock
  input wire logic             reset_n,              // reset, active low
  input wire logic             symmetricBusRequestN, // cpu request
  input wire logic             priorityBusRequestN,  // hub request
  input wire logic             cpuDataOeN,           // cpu drives
  input wire logic             hubDataOeN,           // hub drives
  input wire logic             cpuReadyN,            // cpu ready
  input wire logic             hubReadyN,            // hub ready
  input wire logic [NGRP-1:0]  cpuStbPN,             // cpu pos strobes
  input wire logic [NGRP-1:0]  cpuStbNN,             // cpu neg strobes
  input wire logic [BPM_W-1:0] cpuBpmOeN             // monitor enables
);
  default clocking @(posedge linkClk); endclocking
  default disable iff (!reset_n);
  sequence burst_s;
    !cpuDataOeN [*4] ##1 cpuDataOeN;
  endsequence
  // one strobe fall per beat, all groups alike
  sequence pair_s;
    cpuStbPN == 4'h0 && cpuStbNN == 4'hF ##1
    cpuStbPN == 4'hF && cpuStbNN == 4'h0;
  endsequence
  chk_cpu_burst: assert property ($fell(cpuDataOeN) |-> burst_s)
    else $error("cpu burst not four beats");
  chk_strobe_pairs: assert property ($fell(cpuDataOeN) |-> pair_s ##1 pair_s)
    else $error("strobe pattern wrong");
  chk_ready_marks: assert property ((cpuReadyN == cpuDataOeN) &&
    (hubReadyN == hubDataOeN)) else $error("data ready not with data");
  chk_one_driver: assert property (cpuDataOeN || hubDataOeN)
    else $error("both ends drive");
  chk_no_new_req: assert property ($fell(symmetricBusRequestN) |->
    $past(priorityBusRequestN)) else $error("request under priority");
  chk_cpu_owns: assert property (!cpuDataOeN |-> !symmetricBusRequestN)
    else $error("cpu drives without request");
  chk_hub_waits: assert property ($fell(hubDataOeN) |->
    symmetricBusRequestN && !priorityBusRequestN) else $error("hub early");
  chk_hub_holds: assert property (!hubDataOeN |-> !priorityBusRequestN)
    else $error("priority dropped in transfer");
  chk_bpm_outputs: assert property (cpuBpmOeN[2:1] == 2'h0)
    else $error("output-only monitor lines released");
endmodule
`default_nettype wire

// ### tb/test_host_bus_arbitration_and_data_phase.sv
// bench: processor end and hub end joined by the link interface
// assumes package, interface, design ends and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module test_host_bus_arbitration_and_data_phase;
  import fsb_pkg::*;
  logic              clk_sys, linkClk, reset_n, wrValid, sendValid, bpmProbe;
  logic              wrReady, sendReady, rdValid, recvValid, freqMismatch;
  logic [LINE_W-1:0] wrData, sendData, rdData, recvData;
  logic [FREQ_W-1:0] expectFreq;
  logic [BPM_W-1:0]  bpmEvent, cpuSeen, hubSeen;
  int                fail_count, cmp_count, cycles;
  fsb_link_if u_fsb_link_if (.linkClk(linkClk));
  fsb_cpu_end u_fsb_cpu_end (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(u_fsb_link_if), .wrValid(wrValid), .wrData(wrData),
    .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData),
    .lockedOp(1'b0), .freqStrap(3'h5), .bpmEvent(bpmEvent),
    .bpmProbe(bpmProbe), .bpmSeen(cpuSeen));
  fsb_hub_end u_fsb_hub_end (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(u_fsb_link_if), .sendValid(sendValid), .sendData(sendData),
    .sendReady(sendReady), .recvValid(recvValid), .recvData(recvData),
    .expectFreq(expectFreq), .freqMismatch(freqMismatch),
    .bpmSeen(hubSeen));
  fsb_link_sva chk (.linkClk(linkClk), .reset_n(reset_n),
    .symmetricBusRequestN(u_fsb_link_if.symmetricBusRequestN),
    .priorityBusRequestN(u_fsb_link_if.priorityBusRequestN),
    .cpuDataOeN(u_fsb_link_if.cpuDataOeN),
    .hubDataOeN(u_fsb_link_if.hubDataOeN),
    .cpuReadyN(u_fsb_link_if.cpuReadyN), .hubReadyN(u_fsb_link_if.hubReadyN),
    .cpuStbPN(u_fsb_link_if.cpuStbPN), .cpuStbNN(u_fsb_link_if.cpuStbNN),
    .cpuBpmOeN(u_fsb_link_if.cpuBpmOeN));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #62.5 linkClk = ~linkClk;
  end
  task automatic check(input logic [LINE_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [LINE_W-1:0] mk(input logic [7:0] s);
    logic [LINE_W-1:0] v;
    for (int i = 0; i < NGRP * BEATS; i++) v[i*GRP_W +: GRP_W] = {s, 8'(i)};
    return v;
  endfunction
  task automatic waitRx(input logic hub, input logic [7:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((hub ? recvValid : rdValid) !== 1'b1 && n < 600);
    check(hub ? recvData : rdData, mk(s));
  endtask
  task automatic sendHub(input logic [7:0] s);
    sendValid <= 1'b1;
    sendData <= mk(s);
    do @(posedge clk_sys); while (sendReady !== 1'b1);
    sendValid <= 1'b0;
  endtask
  task automatic sendCpu(input int n, input logic [7:0] s, output int k);
    k = 0;
    wrValid <= 1'b1;
    wrData <= mk(s);
    do begin
      @(posedge clk_sys);
      if (wrReady === 1'b1) k++;
      wrData <= mk(s + 8'(k));
    end while (k < n && (wrReady === 1'b1 || k == 0));
    wrValid <= 1'b0;
  endtask
  task automatic t_burst;
    int k;
    sendCpu(3, 8'h10, k);
    for (int i = 0; i < 3; i++) waitRx(1'b1, 8'h10 + 8'(i));
    $display("burst cpu to hub done");
  endtask
  task automatic t_fill;
    int k;
    sendCpu(40, 8'hA0, k);
    check(LINE_W'(k < 40), LINE_W'(1));
    for (int i = 0; i < k; i++) waitRx(1'b1, 8'hA0 + 8'(i));
    $display("fill and drain done");
  endtask
  task automatic t_both;
    int k;
    fork
      sendCpu(1, 8'h70, k);
      sendHub(8'h80);
    join
    fork
      waitRx(1'b1, 8'h70);
      waitRx(1'b0, 8'h80);
    join
    sendHub(8'h90);
    waitRx(1'b0, 8'h90);
    $display("arbitration done");
  endtask
  task automatic t_side;
    bpmEvent <= 4'h6;
    expectFreq <= 3'h2;
    repeat (60) @(posedge clk_sys);
    check(LINE_W'(hubSeen), LINE_W'(4'h6));
    check(LINE_W'(u_fsb_link_if.breakpointMonitorLinesN), LINE_W'(4'h9));
    check(LINE_W'(freqMismatch), LINE_W'(1));
    bpmEvent <= 4'h9;
    expectFreq <= 3'h5;
    repeat (60) @(posedge clk_sys);
    check(LINE_W'(cpuSeen), LINE_W'(4'h9));
    bpmProbe <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check(LINE_W'(cpuSeen), LINE_W'(4'h0));
    check(LINE_W'(freqMismatch), LINE_W'(0));
    check(LINE_W'(u_fsb_link_if.busFrequencySelect), LINE_W'(3'h5));
    $display("monitor and frequency done");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test;
    end
  end
  // reset spans three link edges so the link side resets too
  initial begin
    {reset_n, wrValid, sendValid, bpmProbe} = 4'h0;
    {wrData, sendData} = '0;
    expectFreq = 3'h5;
    bpmEvent = 4'h0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_burst;
    t_both;
    t_fill;
    t_side;
    end_of_test;
  end
endmodule
`default_nettype wire
